// >>> hdl/tws_pkg.sv
// Purpose: Shared constants and types for the two-wire sensor slave port.
// Assumes: Link logic runs on the bus sampling clock, core on mclk.
// Notes:   Event and read-word bundles cross domains as held data.
package tws_pkg;
   // Fixed upper address bits, alert response and general call codes
   localparam logic [3:0] ADDR_FIXED = 4'h9;
   localparam logic [7:0] ARA_CMD    = 8'h19;
   localparam logic [7:0] GC_WRITE   = 8'h00;
   localparam logic [7:0] GC_LATCH   = 8'h04;
   localparam logic [7:0] GC_RESET   = 8'h06;
   localparam logic [4:0] HS_CODE    = 5'h01;
   // Bit counter marks within one byte
   localparam logic [3:0] BYTE_END   = 4'h8;
   localparam logic [3:0] ACK_END    = 4'h9;
   // Bus-stuck timeout, counted on the link sampling clock
   localparam int TIMEOUT_MS  = 54;
   localparam int LINK_CLK_NS = 64;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / LINK_CLK_NS;
   localparam int TMO_W       = 20;
   // Spike filter lengths in link cycles
   localparam logic [3:0] FS_FILT = 4'h2;
   localparam logic [3:0] HS_FILT = 4'h1;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_PTR, S_WDATA, S_GCMD, S_READ, S_ARA, S_SKIP
   } link_state_t;

   typedef enum logic [2:0] {
      EV_PTR, EV_WR, EV_RD, EV_ARA, EV_GC_RST
   } ev_kind_t;

   typedef struct packed {
      ev_kind_t   kind;
      logic [7:0] ptr;
      logic       bsel;
      logic [7:0] data;
   } ev_t;

   typedef struct packed {
      logic [7:0] msb;
      logic [7:0] lsb;
   } rd_word_t;

   typedef struct packed {
      link_state_t      st;
      logic [3:0]       cnt;
      logic [7:0]       sh;
      logic [7:0]       tx;
      logic             oe;
      logic             first;
      logic             last;
      logic             bsel;
      logic [7:0]       ptr;
      logic             hs;
      logic [2:0]       apins;
      logic             latch_pend;
      logic [TMO_W-1:0] tmo_scl;
      logic [TMO_W-1:0] tmo_sda;
      logic             scl_q;
      logic             sda_q;
      logic             ev_tgl;
      ev_t              ev;
      logic             pub_ack;
      rd_word_t         rd;
      logic             sda_lvl;
   } link_t;

   typedef struct packed {
      logic       ev_seen;
      logic       pub_tgl;
      rd_word_t   pub;
      logic [7:0] ptr;
      logic       wr;
      logic       bsel;
      logic [7:0] wdata;
      logic       alert_clr;
      logic       regs_reset;
   } core_t;

   typedef struct packed {
      logic       out;
      logic [3:0] cnt;
   } filt_t;
endpackage

// >>> hdl/sync2.sv
// Purpose: Two-flop level synchroniser, one bit per lane.
// Assumes: Each lane is an independent level.
// Notes:   No reset, so it may feed the reset of the destination.
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,  // Destination clock
   input  wire logic [W-1:0] din,  // Asynchronous levels
   output logic      [W-1:0] dout  // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } sync_t;
   sync_t r;
   sync_t next_r;

   // First stage feeds only the second
   always_comb begin
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign dout = r.s2;
endmodule

// >>> hdl/line_filter.sv
// Purpose: Spike suppression on a synchronised bus line.
// Assumes: Input already passed two flip-flops.
// Notes:   Length shortens in high-speed mode.
`timescale 1ns/100ps
module line_filter (
   input  wire logic clk,   // Link sampling clock
   input  wire logic rst,   // Synchronous reset, high
   input  wire logic din,   // Synchronised line level
   input  wire logic hs,    // High-speed filtering
   output logic      dout   // Filtered level
);
   tws_pkg::filt_t r;
   tws_pkg::filt_t next_r;
   logic [3:0]     lim;

   // A new level must persist for the whole filter length
   always_comb begin
      lim    = hs ? tws_pkg::HS_FILT : tws_pkg::FS_FILT;
      next_r = r;
      if (din == r.out) begin
         next_r.cnt = 4'h0;
      end else if (r.cnt + 4'h1 >= lim) begin
         next_r.out = din;
         next_r.cnt = 4'h0;
      end else begin
         next_r.cnt = r.cnt + 4'h1;
      end
   end

   // Idle bus is high, so the filter starts high
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '{out: 1'b1, cnt: 4'h0};
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.out;
endmodule

// >>> hdl/tws_slave.sv
// Purpose: Two-wire slave port of a temperature sensor.
// Assumes: Register contents, alert logic and conversion live outside.
// Notes:   Link logic oversamples SCL/SDA on bus_clk; mclk side sees
//          one-cycle strobes. A byte lasts far longer than a crossing.
`timescale 1ns/100ps
// Contract
// - Acknowledge a write address only when it matches our own.
// - Byte after write address is the pointer; acknowledge and store it.
// - Store and acknowledge every further write byte until START or STOP.
// - Read sends pointed register MSB first, then LSB after master ack.
// - Master nack, START or STOP ends a read; release SDA.
// - In alert mode with alert active, ack alert command and send address.
// - Returned address LSB is 1 at or above high limit, else 0.
// - Arbitrate returned address bitwise; winner clears alert, loser keeps it.
// - Acknowledge general call write address and treat next byte as command.
// - Command 04 relatches address pins; 06 also resets registers.
// - Do not ack high-speed master code, but switch to high-speed filtering.
// - High-speed stays through repeated STARTs until STOP.
// - A line low about 54ms inside a transfer resets the interface.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - Repeated START and STOP both end the current transaction.
// - An ack holds SDA low through the whole ninth clock high.
// - Bus is idle with both lines high and no transfer.
// - Address is 1001 then the three pins, latched at reset, start, call.
// - Read uses the last written pointer until another write.
// - In alert mode, any read or won alert response clears alert.
// - Bytes travel most significant bit first.
module tws_slave #(
   parameter int TIMEOUT_CYC = tws_pkg::TIMEOUT_CYC
) (
   input  wire logic       mclk,              // Core clock, 100 MHz
   input  wire logic       rst,               // Synchronous reset, high
   input  wire logic       bus_clk,           // Link sampling clock
   input  wire logic       scl_in,            // SCL pin level
   input  wire logic       sda_in,            // SDA pin level
   output logic            sda_out,           // SDA drive level, always 0
   output logic            sda_oe,            // High pulls SDA low
   input  wire logic       addr_pin_hi,       // Address pin, bit 2
   input  wire logic       addr_pin_mid,      // Address pin, bit 1
   input  wire logic       addr_pin_lo,       // Address pin, bit 0
   input  wire logic       alert_mode_select, // 1 = interrupt alert mode
   input  wire logic       alert_active,      // Alert output is active
   input  wire logic       temp_high,         // Temp at or above high limit
   input  wire logic [7:0] rd_msb,            // MSB of register at reg_ptr
   input  wire logic [7:0] rd_lsb,            // LSB of register at reg_ptr
   output logic      [7:0] reg_ptr,           // Current pointer
   output logic            wr_strobe,         // Write one byte, pulse
   output logic            wr_lsb_sel,        // Byte written is the LSB
   output logic      [7:0] wr_data,           // Byte to write
   output logic            alert_clr,         // Clear the alert, pulse
   output logic            regs_reset,        // Restore power-up values
   output logic            hs_mode            // High-speed filtering on
);
   tws_pkg::link_t l;
   tws_pkg::link_t next_l;
   tws_pkg::core_t c;
   tws_pkg::core_t next_c;
   logic [7:0]     lsync;
   logic [1:0]     pin_s;
   logic [1:0]     msync;
   logic           brst;
   logic           scl_f;
   logic           sda_f;
   logic           rise;
   logic           fall;
   logic           start;
   logic           stop;
   logic           tmo_hit;
   logic [6:0]     my_addr;
   logic [7:0]     b;

   // Levels from the core and pins into the link domain
   sync2 #(.W(8)) u_lsync (
      .clk  (bus_clk),
      .din  ({rst, c.pub_tgl, alert_active, alert_mode_select, temp_high,
              addr_pin_hi, addr_pin_mid, addr_pin_lo}),
      .dout (lsync)
   );
   assign brst = lsync[7];

   sync2 #(.W(2)) u_pins (
      .clk  (bus_clk),
      .din  ({scl_in, sda_in}),
      .dout (pin_s)
   );

   line_filter u_scl_f (
      .clk  (bus_clk),
      .rst  (brst),
      .din  (pin_s[1]),
      .hs   (l.hs),
      .dout (scl_f)
   );

   line_filter u_sda_f (
      .clk  (bus_clk),
      .rst  (brst),
      .din  (pin_s[0]),
      .hs   (l.hs),
      .dout (sda_f)
   );

   // Bus conditions from filtered samples only
   assign rise    = scl_f & ~l.scl_q;
   assign fall    = ~scl_f & l.scl_q;
   assign start   = scl_f & l.scl_q & l.sda_q & ~sda_f;
   assign stop    = scl_f & l.scl_q & ~l.sda_q & sda_f;
   assign tmo_hit = (32'(l.tmo_scl) >= TIMEOUT_CYC - 1) |
                    (32'(l.tmo_sda) >= TIMEOUT_CYC - 1);
   assign my_addr = {tws_pkg::ADDR_FIXED, l.apins};
   assign b       = l.sh;

   function automatic logic is_tx(input tws_pkg::link_state_t s);
      is_tx = (s == tws_pkg::S_READ) || (s == tws_pkg::S_ARA);
   endfunction

   // Low-time counter: clears while the line is high, sticks at the top
   function automatic logic [tws_pkg::TMO_W-1:0] sat_inc(
      input logic [tws_pkg::TMO_W-1:0] v,
      input logic                      low
   );
      sat_inc = !low ? '0 : ((&v) ? v : v + 1'b1);
   endfunction

   // Link engine: one step per filtered bus event
   always_comb begin
      next_l         = l;
      next_l.scl_q   = scl_f;
      next_l.sda_q   = sda_f;
      next_l.tmo_scl = sat_inc(l.tmo_scl, ~scl_f);
      next_l.tmo_sda = sat_inc(l.tmo_sda, ~sda_f);
      if (l.latch_pend) begin
         next_l.apins      = lsync[2:0];
         next_l.latch_pend = 1'b0;
      end
      // Fresh read word from the core, handshaked
      if (lsync[6] != l.pub_ack) begin
         next_l.rd      = c.pub;
         next_l.pub_ack = lsync[6];
      end
      if (start) begin
         // A repeated START ends the transfer but keeps high-speed
         next_l.st    = tws_pkg::S_ADDR;
         next_l.cnt   = 4'h0;
         next_l.oe    = 1'b0;
         next_l.first = 1'b1;
         next_l.last  = 1'b0;
         next_l.apins = lsync[2:0];
      end else if (stop) begin
         next_l.st = tws_pkg::S_IDLE;
         next_l.oe = 1'b0;
         next_l.hs = 1'b0;
      end else if (tmo_hit && l.st != tws_pkg::S_IDLE) begin
         next_l.st = tws_pkg::S_IDLE;
         next_l.oe = 1'b0;
      end else if (l.st == tws_pkg::S_IDLE ||
                   l.st == tws_pkg::S_SKIP) begin
         next_l.oe = 1'b0;
      end else if (rise) begin
         next_l.cnt = l.cnt + 4'h1;
         if (l.cnt < tws_pkg::BYTE_END) begin
            next_l.sh = {l.sh[6:0], sda_f};
            // Driving high but reading low: another device won
            if (l.st == tws_pkg::S_ARA && !l.oe && !sda_f) begin
               next_l.st = tws_pkg::S_SKIP;
            end
         end else if (l.st == tws_pkg::S_READ && sda_f) begin
            next_l.st = tws_pkg::S_SKIP;
         end
      end else if (fall) begin
         if (l.cnt == tws_pkg::BYTE_END) begin
            next_l.oe = 1'b0;
            unique case (l.st)
               tws_pkg::S_ADDR: begin
                  if (l.first && b[7:3] == tws_pkg::HS_CODE) begin
                     next_l.hs = 1'b1;
                     next_l.st = tws_pkg::S_SKIP;
                  end else if (b[7:1] == my_addr) begin
                     next_l.oe = 1'b1;
                     if (b[0]) begin
                        next_l.st   = tws_pkg::S_READ;
                        next_l.bsel = 1'b0;
                        next_l.tx   = l.rd.msb;
                        next_l.ev   = '{tws_pkg::EV_RD, l.ptr, 1'b0, b};
                        next_l.ev_tgl = ~l.ev_tgl;
                     end else begin
                        next_l.st = tws_pkg::S_PTR;
                     end
                  end else if (b == tws_pkg::ARA_CMD && lsync[5] &&
                               lsync[4]) begin
                     next_l.oe = 1'b1;
                     next_l.st = tws_pkg::S_ARA;
                     next_l.tx = {my_addr, lsync[3]};
                  end else if (b == tws_pkg::GC_WRITE) begin
                     next_l.oe = 1'b1;
                     next_l.st = tws_pkg::S_GCMD;
                  end else begin
                     next_l.st = tws_pkg::S_SKIP;
                  end
               end
               tws_pkg::S_PTR: begin
                  next_l.oe     = 1'b1;
                  next_l.ptr    = b;
                  next_l.bsel   = 1'b0;
                  next_l.st     = tws_pkg::S_WDATA;
                  next_l.ev     = '{tws_pkg::EV_PTR, b, 1'b0, b};
                  next_l.ev_tgl = ~l.ev_tgl;
               end
               tws_pkg::S_WDATA: begin
                  next_l.oe     = 1'b1;
                  next_l.bsel   = ~l.bsel;
                  next_l.ev     = '{tws_pkg::EV_WR, l.ptr, l.bsel, b};
                  next_l.ev_tgl = ~l.ev_tgl;
               end
               tws_pkg::S_GCMD: begin
                  next_l.oe   = 1'b1;
                  next_l.last = 1'b1;
                  if (b == tws_pkg::GC_LATCH || b == tws_pkg::GC_RESET) begin
                     next_l.latch_pend = 1'b1;
                  end
                  if (b == tws_pkg::GC_RESET) begin
                     next_l.ptr    = 8'h00;
                     next_l.ev     = '{tws_pkg::EV_GC_RST, 8'h00, 1'b0, b};
                     next_l.ev_tgl = ~l.ev_tgl;
                  end
               end
               tws_pkg::S_READ: begin
                  // Release for the master's ack, queue the other byte
                  next_l.bsel = ~l.bsel;
                  next_l.tx   = l.bsel ? l.rd.msb : l.rd.lsb;
               end
               tws_pkg::S_ARA: begin
                  next_l.st     = tws_pkg::S_SKIP;
                  next_l.ev     = '{tws_pkg::EV_ARA, l.ptr, 1'b0, b};
                  next_l.ev_tgl = ~l.ev_tgl;
               end
               default: next_l.st = tws_pkg::S_SKIP;
            endcase
         end else if (l.cnt == tws_pkg::ACK_END) begin
            // Ack held through the ninth clock high, freed here
            next_l.cnt   = 4'h0;
            next_l.first = 1'b0;
            next_l.oe    = is_tx(l.st) & ~l.tx[7];
            if (l.last) begin
               next_l.st = tws_pkg::S_SKIP;
               next_l.oe = 1'b0;
            end
         end else if (l.cnt != 4'h0 && is_tx(l.st)) begin
            next_l.oe = ~l.tx[3'(4'h7 - l.cnt)];
         end
      end
   end

   always_ff @(posedge bus_clk) begin
      if (brst) begin
         l            <= '0;
         l.scl_q      <= 1'b1;
         l.sda_q      <= 1'b1;
         l.latch_pend <= 1'b1;
      end else begin
         l <= next_l;
      end
   end

   assign sda_out = l.sda_lvl;
   assign sda_oe  = l.oe;
   assign hs_mode = l.hs;

   // Link toggles and handshake ack into the core domain
   sync2 #(.W(2)) u_msync (
      .clk  (mclk),
      .din  ({l.ev_tgl, l.pub_ack}),
      .dout (msync)
   );

   // Core side: turn link events into strobes, publish the read word
   always_comb begin
      next_c            = c;
      next_c.wr         = 1'b0;
      next_c.alert_clr  = 1'b0;
      next_c.regs_reset = 1'b0;
      if (msync[1] != c.ev_seen) begin
         next_c.ev_seen = msync[1];
         unique case (l.ev.kind)
            tws_pkg::EV_PTR: next_c.ptr = l.ev.ptr;
            tws_pkg::EV_WR: begin
               next_c.wr    = 1'b1;
               next_c.bsel  = l.ev.bsel;
               next_c.wdata = l.ev.data;
            end
            tws_pkg::EV_RD,
            tws_pkg::EV_ARA: next_c.alert_clr = alert_mode_select;
            tws_pkg::EV_GC_RST: begin
               next_c.regs_reset = 1'b1;
               next_c.ptr        = 8'h00;
            end
            default: ;
         endcase
      end
      if (msync[0] == c.pub_tgl) begin
         next_c.pub     = '{rd_msb, rd_lsb};
         next_c.pub_tgl = ~c.pub_tgl;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   assign reg_ptr    = c.ptr;
   assign wr_strobe  = c.wr;
   assign wr_lsb_sel = c.bsel;
   assign wr_data    = c.wdata;
   assign alert_clr  = c.alert_clr;
   assign regs_reset = c.regs_reset;

   // Checks on the link engine
   default clocking cb @(posedge bus_clk); endclocking
   default disable iff (brst);

   sequence s_byte_end(tws_pkg::link_state_t s);
      fall && !start && !stop && !tmo_hit && l.st == s &&
      l.cnt == tws_pkg::BYTE_END;
   endsequence

   property p_addr_ack;
      s_byte_end(tws_pkg::S_ADDR) ##0 (b[7:1] == my_addr)
      |=> l.oe;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acknowledged");

   property p_ptr_store;
      s_byte_end(tws_pkg::S_PTR) |=> l.oe && l.ptr == $past(b)
         && l.ev_tgl != $past(l.ev_tgl);
   endproperty
   a_ptr_store: assert property (p_ptr_store)
      else $error("pointer byte not stored");

   property p_rd_msb;
      s_byte_end(tws_pkg::S_ADDR) ##0 (b == {my_addr, 1'b1})
      |=> l.st == tws_pkg::S_READ && l.tx == $past(l.rd.msb);
   endproperty
   a_rd_msb: assert property (p_rd_msb)
      else $error("read did not start with the MSB");

   property p_nack_end;
      rise && !start && !stop && !tmo_hit && l.st == tws_pkg::S_READ
      && l.cnt == tws_pkg::BYTE_END && sda_f
      |=> l.st == tws_pkg::S_SKIP ##1 !l.oe [*3];
   endproperty
   a_nack_end: assert property (p_nack_end)
      else $error("SDA not released after master nack");

   property p_arb_lost;
      rise && !start && !stop && !tmo_hit && l.st == tws_pkg::S_ARA &&
      l.cnt < tws_pkg::BYTE_END && !l.oe && !sda_f
      |=> l.st == tws_pkg::S_SKIP && !l.oe;
   endproperty
   a_arb_lost: assert property (p_arb_lost)
      else $error("lost arbitration not honoured");

   property p_hs_code;
      s_byte_end(tws_pkg::S_ADDR) ##0 (l.first && b[7:3] == tws_pkg::HS_CODE)
      |=> l.hs && !l.oe;
   endproperty
   a_hs_code: assert property (p_hs_code)
      else $error("high-speed code acked or ignored");

   property p_hs_stop;
      stop |=> !l.hs && l.st == tws_pkg::S_IDLE;
   endproperty
   a_hs_stop: assert property (p_hs_stop)
      else $error("high-speed kept after STOP");

   property p_timeout;
      !start && !stop && tmo_hit && l.st != tws_pkg::S_IDLE
      |=> l.st == tws_pkg::S_IDLE && !l.oe;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("bus timeout did not reset the interface");

   property p_start;
      start |=> l.st == tws_pkg::S_ADDR && l.cnt == 4'h0 && !l.oe;
   endproperty
   a_start: assert property (p_start)
      else $error("START not taken");
endmodule

// >>> tb/tws_master.sv
// Purpose: Behavioural two-wire bus master for the slave port bench.
// Assumes: SDA has a pull-up; the slave only pulls it low.
// Notes:   Lines move on mclk falls; a half bit is 64 mclk.
`timescale 1ns/100ps
module tws_master (
   input  wire logic mclk,   // Bench clock
   input  wire logic sda_oe, // Slave pulls SDA low
   output logic      scl,    // Clock line
   output logic      sda     // Resolved data line
);
   logic drv_low = 1'b0; // Master pulls SDA low
   // Wired-AND with pull-up; both lines idle high
   assign sda = ~(drv_low | sda_oe);
   initial scl = 1'b1;
   task automatic half();
      repeat (64) @(negedge mclk);
   endtask
   // Data moves 16 mclk into SCL low so it never looks like a STOP
   task automatic bitx(input logic v, output logic s);
      repeat (16) @(negedge mclk);
      drv_low = ~v;
      half();
      scl = 1'b1;
      half();
      s = sda;
      scl = 1'b0;
   endtask
   // SDA falls while SCL high, also as a repeated START
   task automatic start();
      repeat (16) @(negedge mclk);
      drv_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      drv_low = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      repeat (16) @(negedge mclk);
      drv_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      drv_low = 1'b0;
      half();
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(v[i], s);
      end
      bitx(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, v[i]);
      end
      bitx(~ack, s);
   endtask
endmodule

// >>> tb/tb_tws_slave.sv
// Purpose: Self-checking bench for the two-wire slave port.
// Assumes: Master model owns SCL and SDA; bench drives the rest.
// Notes:   Short timeout parameter keeps the stuck-bus case brief.
`timescale 1ns/100ps
module tb_tws_slave;
   localparam logic [2:0] PINS = 3'h5;
   localparam logic [7:0] AW = {tws_pkg::ADDR_FIXED, PINS, 1'b0};
   logic mclk = 1'b0, bus_clk = 1'b0, rst = 1'b1;
   logic mode = 1'b1, alrt = 1'b0, hot = 1'b0;
   logic scl, sda, sda_out, sda_oe, wr_strobe, wr_lsb_sel, sel, a;
   logic alert_clr, regs_reset, hs_mode;
   logic [7:0] rd_msb = 8'hC3, rd_lsb = 8'h3C, reg_ptr, wr_data, wd, b;
   logic [15:0] n_wr = 16'h0, n_clr = 16'h0, n_rst = 16'h0;
   int err_total = 0, checks_done = 0, cyc = 0;
   always #5 mclk = ~mclk;
   always #32 bus_clk = ~bus_clk;
   tws_master i_tws_master (.mclk(mclk), .sda_oe(sda_oe), .scl(scl),
      .sda(sda));
   tws_slave #(.TIMEOUT_CYC(200)) i_tws_slave (.mclk(mclk), .rst(rst),
      .bus_clk(bus_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_pin_hi(PINS[2]), .addr_pin_mid(PINS[1]),
      .addr_pin_lo(PINS[0]), .alert_mode_select(mode), .alert_active(alrt),
      .temp_high(hot), .rd_msb(rd_msb), .rd_lsb(rd_lsb), .reg_ptr(reg_ptr),
      .wr_strobe(wr_strobe), .wr_lsb_sel(wr_lsb_sel), .wr_data(wr_data),
      .alert_clr(alert_clr), .regs_reset(regs_reset), .hs_mode(hs_mode));
   // Pulse tallies and the hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (wr_strobe === 1'b1) begin
         n_wr <= n_wr + 16'h1;
         wd <= wr_data;
         sel <= wr_lsb_sel;
      end
      if (alert_clr === 1'b1) n_clr <= n_clr + 16'h1;
      if (regs_reset === 1'b1) n_rst <= n_rst + 16'h1;
      if (cyc == 80000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Holds SCL low a while so core-side results settle
   task automatic wb(input logic [7:0] v, input logic exp);
      i_tws_master.wbyte(v, a);
      chk(16'(a), 16'(exp));
      repeat (100) @(negedge mclk);
   endtask
   task automatic rb(input logic ack, input logic [7:0] exp);
      i_tws_master.rbyte(ack, b);
      chk(16'(b), 16'(exp));
   endtask
   initial begin
      repeat (4) @(posedge bus_clk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (40) @(negedge mclk);
      i_tws_master.start();
      wb(AW, 1'b1);
      wb(8'h03, 1'b1);
      chk(16'(reg_ptr), 16'h0003);
      wb(8'hA5, 1'b1);
      chk({wd, 7'h0, sel}, 16'hA500);
      wb(8'h5A, 1'b1);
      chk({wd, 7'h0, sel}, 16'h5A01);
      i_tws_master.stop();
      i_tws_master.start();
      wb(8'h92, 1'b0);
      wb(8'h00, 1'b0);
      i_tws_master.stop();
      i_tws_master.start();
      wb(AW | 8'h01, 1'b1);
      rb(1'b1, 8'hC3);
      rb(1'b0, 8'h3C);
      chk(16'(sda_oe), 16'h0);
      chk(n_clr, 16'h1);
      i_tws_master.stop();
      chk(n_wr, 16'h2);
      alrt = 1'b1;
      hot = 1'b1;
      i_tws_master.start();
      wb(tws_pkg::ARA_CMD, 1'b1);
      rb(1'b0, {tws_pkg::ADDR_FIXED, PINS, 1'b1});
      i_tws_master.stop();
      chk(n_clr, 16'h2);
      // Another responder pulls SDA low, so this one loses
      i_tws_master.start();
      wb(tws_pkg::ARA_CMD, 1'b1);
      for (int i = 0; i < 9; i++) begin
         i_tws_master.bitx(i == 8, a);
      end
      i_tws_master.stop();
      chk(n_clr, 16'h2);
      mode = 1'b0;
      i_tws_master.start();
      wb(tws_pkg::ARA_CMD, 1'b0);
      i_tws_master.stop();
      i_tws_master.start();
      wb(tws_pkg::GC_WRITE, 1'b1);
      wb(tws_pkg::GC_LATCH, 1'b1);
      i_tws_master.start();
      wb(tws_pkg::GC_WRITE, 1'b1);
      wb(tws_pkg::GC_RESET, 1'b1);
      i_tws_master.stop();
      chk(n_rst, 16'h1);
      chk(16'(reg_ptr), 16'h0000);
      i_tws_master.start();
      wb(8'h0D, 1'b0);
      chk(16'(hs_mode), 16'h1);
      i_tws_master.start();
      wb(AW, 1'b1);
      chk(16'(hs_mode), 16'h1);
      i_tws_master.stop();
      chk(16'(hs_mode), 16'h0);
      // Stop clocking inside the address acknowledge
      i_tws_master.start();
      for (int i = 7; i >= 0; i--) begin
         i_tws_master.bitx(AW[i], a);
      end
      repeat (40) @(negedge mclk);
      chk(16'(sda_oe), 16'h1);
      chk(16'(sda_out), 16'h0000);
      repeat (1500) @(negedge mclk);
      chk(16'(sda_oe), 16'h0);
      i_tws_master.stop();
      finish_test();
   end
endmodule
